// File: hw/sld_map.vh
/*
   Constants for the 32-stage serial-in latched sink driver block.
   Assumes inclusion by bare name from the design file under hw/.
*/
`ifndef SLD_MAP_VH
`define SLD_MAP_VH

// Number of shift stages, latches and sink outputs
`define SLD_STAGES 32
// Words of buffering between the pin sampler and the shift register
`define SLD_FIFO_DEPTH 16
`define SLD_FIFO_AW 4
// Width of one buffered word: one serial data bit
`define SLD_FIFO_WIDTH 1
// System clock rate in Hz
`define SLD_MCLK_HZ 25000000
// Highest supported shift clock rate in Hz
`define SLD_SHIFT_MAX_HZ 10000000
// Least system clocks per shift clock period (floor of the ratio)
`define SLD_SHIFT_MIN_CYCLES (`SLD_MCLK_HZ / `SLD_SHIFT_MAX_HZ)
// Reset values
`define SLD_RESET_STAGES 32'h00000000
`define SLD_RESET_LATCHES 32'h00000000
`define SLD_RESET_SINK 32'h00000000

`endif

// File: hw/sld_top.v
/*
   Serial-in, latched, gated 32-output sink driver, with the FIFO that
   carries sampled serial bits into the shift register.
   Assumes all host pins are asynchronous to MCLK and that the host shift
   clock stays at or below 10 MHz, so every level lasts over one MCLK period.
*/
// How it works
// - A rising edge of the shift clock takes the serial data level into the first stage.
// - Every later rising edge moves each stage's old value one place toward the output.
// - The shift register has 32 stages, one for each sink output.
// - Each sink output has its own latch fed from its own shift stage.
// - While the strobe is high every latch copies its shift stage.
// - The latches keep following the shift register as long as the strobe stays high.
// - With output enable low all 32 sink outputs are off whatever the latches hold.
// - Output enable never alters the latch contents, it only gates the outputs.
// - With output enable high each sink output follows its own latch.
// - The last shift stage is driven out on the serial data output for cascading.
// - The serial data output changes after a shift clock rising edge with the new last stage.
// - The shift clock may run up to 10 MHz and the host keeps within that.
`timescale 1ns/100ps
`default_nettype none
`include "sld_map.vh"

module sld_fifo
#(
   parameter WIDTH = `SLD_FIFO_WIDTH,
   parameter DEPTH = `SLD_FIFO_DEPTH,
   parameter AW = `SLD_FIFO_AW
)
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire full;
   wire empty;
   wire push;
   wire pop;

   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointers
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + {{AW{1'h0}}, 1'h1};
         if (pop)
            rd_ptr <= rd_ptr + {{AW{1'h0}}, 1'h1};
      end
   end

   // Storage, no reset needed
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule // sld_fifo

module sld_sync
#(
   parameter RESET_VAL = 1'h0
)
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Asynchronous pin and its settled copy
   input wire pin,
   output wire level
);
   reg capture;
   reg settled;

   assign level = settled;

   // Only the second flop is read outside, the first may go metastable
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         capture <= RESET_VAL;
         settled <= RESET_VAL;
      end
      else
      begin
         capture <= pin;
         settled <= capture;
      end
   end
endmodule // sld_sync

module sld_cell
#(
   parameter STAGE_INIT = 1'h0,
   parameter LATCH_INIT = 1'h0
)
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Shift path
   input wire shift_en,
   input wire shift_in,
   output wire stage_q,
   output wire stage_next,
   // Latch path
   input wire load,
   output wire latch_next
);
   reg stage_bit;
   reg latch_bit;

   assign stage_q = stage_bit;
   assign stage_next = shift_en ? shift_in : stage_bit;
   assign latch_next = load ? stage_next : latch_bit;

   // One shift stage and its own storage latch
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stage_bit <= STAGE_INIT;
         latch_bit <= LATCH_INIT;
      end
      else
      begin
         stage_bit <= stage_next;
         latch_bit <= latch_next;
      end
   end
endmodule // sld_cell

module sld_top
(
   // Clock and reset
   input wire MCLK,
   input wire RST,
   // Host pins
   input wire SERIAL_IN,
   input wire SHIFT_CLK,
   input wire STROBE,
   input wire OUT_ENABLE,
   // Cascade output
   output reg SERIAL_OUT,
   // Sink driver controls, high turns a sink on
   output reg [`SLD_STAGES-1:0] SINK_ON,
   // Buffer status, low when a sampled bit would be dropped
   output wire SHIFT_READY
);
   localparam [`SLD_STAGES-1:0] STAGE_INIT = `SLD_RESET_STAGES;
   localparam [`SLD_STAGES-1:0] LATCH_INIT = `SLD_RESET_LATCHES;
   wire shift_clk_level;
   wire data_level;
   wire strobe_level;
   wire oe_level;
   reg shift_clk_prev;
   wire [`SLD_STAGES-1:0] stages;
   wire [`SLD_STAGES-1:0] shift_chain;
   wire [`SLD_STAGES-1:0] next_stages;
   wire [`SLD_STAGES-1:0] next_latches;
   genvar i;
   wire shift_rise;
   wire fifo_valid;
   wire fifo_data;
   wire take_bit;

   // Two-flop synchronisers, one for each host pin
   sld_sync #(
      .RESET_VAL(1'h0)
   ) u_sync_clk (
      .clk(MCLK),
      .rst(RST),
      .pin(SHIFT_CLK),
      .level(shift_clk_level)
   );

   sld_sync #(
      .RESET_VAL(1'h0)
   ) u_sync_data (
      .clk(MCLK),
      .rst(RST),
      .pin(SERIAL_IN),
      .level(data_level)
   );

   sld_sync #(
      .RESET_VAL(1'h0)
   ) u_sync_strobe (
      .clk(MCLK),
      .rst(RST),
      .pin(STROBE),
      .level(strobe_level)
   );

   sld_sync #(
      .RESET_VAL(1'h0)
   ) u_sync_oe (
      .clk(MCLK),
      .rst(RST),
      .pin(OUT_ENABLE),
      .level(oe_level)
   );

   // History of the settled shift clock, idle low so reset makes no false edge
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
         shift_clk_prev <= 1'h0;
      else
         shift_clk_prev <= shift_clk_level;
   end

   // Data is delayed as far as the clock, so the bit set up before the edge is taken
   assign shift_rise = shift_clk_level & ~shift_clk_prev;

   sld_fifo #(
      .WIDTH(`SLD_FIFO_WIDTH),
      .DEPTH(`SLD_FIFO_DEPTH),
      .AW(`SLD_FIFO_AW)
   ) u_fifo (
      .clk(MCLK),
      .rst(RST),
      .in_valid(shift_rise),
      .in_ready(SHIFT_READY),
      .in_data(data_level),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_data)
   );

   assign take_bit = fifo_valid;

   // Each stage takes its neighbour's old value, stage 0 the new bit
   assign shift_chain = {stages[`SLD_STAGES-2:0], fifo_data};

   // One shift stage and one latch per sink output
   generate
      for (i = 0; i < `SLD_STAGES; i = i + 1)
      begin : g_cell
         sld_cell #(
            .STAGE_INIT(STAGE_INIT[i]),
            .LATCH_INIT(LATCH_INIT[i])
         ) u_cell (
            .clk(MCLK),
            .rst(RST),
            .shift_en(take_bit),
            .shift_in(shift_chain[i]),
            .stage_q(stages[i]),
            .stage_next(next_stages[i]),
            .load(strobe_level),
            .latch_next(next_latches[i])
         );
      end
   endgenerate

   // Registered outputs; enable gates the sinks only, never the latches
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         SERIAL_OUT <= 1'h0;
         SINK_ON <= `SLD_RESET_SINK;
      end
      else
      begin
         SERIAL_OUT <= next_stages[`SLD_STAGES-1];
         if (oe_level)
            SINK_ON <= next_latches;
         else
            SINK_ON <= `SLD_RESET_SINK;
      end
   end
endmodule // sld_top

`default_nettype wire

// File: test/sld_chk.sv
/* Pin checker for sld_top, bound below.
   Assumes pins settle between MCLK edges. */
`timescale 1ns/100ps
`default_nettype none
module sld_chk
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Host pins
   input wire logic SERIAL_IN,
   input wire logic SHIFT_CLK,
   input wire logic STROBE,
   input wire logic OUT_ENABLE,
   // Outputs
   input wire logic SERIAL_OUT,
   input wire logic SHIFT_READY,
   input wire logic [31:0] SINK_ON
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   chk_sink_off: assert property (!OUT_ENABLE [*4] |-> SINK_ON == 32'h0)
      else $error("sink on while disabled");
   chk_ready_high: assert property (SHIFT_READY)
      else $error("shift bit dropped");
   chk_sout_cause: assert property ($changed(SERIAL_OUT) |->
      $past(SHIFT_CLK, 4) || $past(SHIFT_CLK, 5)) else $error("serial out moved alone");
   chk_sout_idle: assert property (!SHIFT_CLK [*8] |=> $stable(SERIAL_OUT))
      else $error("serial out moved while idle");
   chk_latch_hold: assert property ((!STROBE && OUT_ENABLE) [*6] |=> $stable(SINK_ON))
      else $error("latch moved with strobe low");
   chk_sink_cause: assert property ($changed(SINK_ON) |->
      $past(STROBE, 3) || $past(STROBE, 4) || $past(STROBE, 5) ||
      $past(OUT_ENABLE, 3) != $past(OUT_ENABLE, 4)) else $error("sinks moved alone");
   chk_sink_gate: assert property (SINK_ON != 32'h0 |-> $past(OUT_ENABLE, 3))
      else $error("sink on without enable");
   chk_reset_clear: assert property (disable iff (1'b0)
      RST |=> !SERIAL_OUT && SINK_ON == 32'h0) else $error("outputs not cleared");
   cover property (STROBE && OUT_ENABLE);
   cover property ($rose(SHIFT_CLK) && SERIAL_IN);
   cover property ($fell(OUT_ENABLE));
   cover property (!STROBE && $rose(SHIFT_CLK));
endmodule // sld_chk
bind sld_top sld_chk chk_u (.MCLK, .RST, .SERIAL_IN, .SHIFT_CLK, .STROBE, .OUT_ENABLE,
   .SERIAL_OUT, .SHIFT_READY, .SINK_ON);
`default_nettype wire

// File: test/sld_host.sv
/* Host model driving the shift clock and serial data.
   Assumes calls start at an MCLK falling edge. */
`timescale 1ns/100ps
`default_nettype none
module sld_host
(
   // Clock
   input wire logic MCLK,
   // Serial pins to the block
   output var logic SERIAL_IN = 1'b0,
   output var logic SHIFT_CLK = 1'b0
);
   // Data set up a low phase ahead, 6 MCLK period
   task send(input logic b);
      SERIAL_IN = b;
      repeat (3) @(negedge MCLK);
      SHIFT_CLK = 1'b1;
      repeat (3) @(negedge MCLK);
      SHIFT_CLK = 1'b0;
   endtask
endmodule // sld_host
`default_nettype wire

// File: test/sld_top_tb.sv
/* Testbench for sld_top.
   Assumes the host model in sld_host and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module sld_top_tb;
   logic MCLK = 1'b0, RST = 1'b1, STROBE = 1'b0, OUT_ENABLE = 1'b0;
   wire logic SERIAL_IN, SHIFT_CLK, SERIAL_OUT, SHIFT_READY;
   wire logic [31:0] SINK_ON;
   int n_errors = 0, n_checks = 0;
   localparam logic [31:0] W = 32'hA5C30F71;
   always #20 MCLK = ~MCLK;
   sld_host host_u (.MCLK, .SERIAL_IN, .SHIFT_CLK);
   sld_top dut_u (.MCLK, .RST, .SERIAL_IN, .SHIFT_CLK, .STROBE, .OUT_ENABLE,
      .SERIAL_OUT, .SINK_ON, .SHIFT_READY);
   task idle(input int n);
      repeat (n) @(negedge MCLK);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task t_load;
      for (int i = 31; i >= 0; i--)
         host_u.send(W[i]);
      idle(6);
      chk(SINK_ON, 32'h0);
      chk({31'h0, SERIAL_OUT}, {31'h0, W[31]});
      STROBE = 1'b1;
      idle(4);
      STROBE = 1'b0;
      idle(6);
      chk(SINK_ON, W);
   endtask
   task t_gate;
      OUT_ENABLE = 1'b0;
      idle(8);
      chk(SINK_ON, 32'h0);
      OUT_ENABLE = 1'b1;
      idle(8);
      chk(SINK_ON, W);
   endtask
   task t_thru;
      STROBE = 1'b1;
      OUT_ENABLE = 1'b0;
      host_u.send(1'b1);
      idle(6);
      chk({31'h0, SERIAL_OUT}, {31'h0, W[30]});
      OUT_ENABLE = 1'b1;
      idle(8);
      chk(SINK_ON, {W[30:0], 1'b1});
   endtask
   initial
   begin
      idle(6);
      RST = 1'b0;
      OUT_ENABLE = 1'b1;
      idle(2);
      t_load;
      t_gate;
      t_thru;
      end_sim;
   end
   initial
   begin
      #100000;
      n_errors++;
      end_sim;
   end
endmodule // sld_top_tb
`default_nettype wire
